// [gpnms_lp_model.sv]
// gpnms_lp_model.sv: remote link partner pages, as handed on by negotiation.
// assumes: send is a one-cycle bench request taken on rising core_clk.
`timescale 1ns/100ps
module gpnms_lp_model (
    // clock
    input wire logic core_clk,
    // bench request
    input wire logic send,
    input wire logic [15:0] word,
    // page toward the block
    output logic page_rx_valid,
    output logic [15:0] page_rx_word
);
    // one-cycle page strobe; word shows its inverse while idle so stale data is never seen
    always @(posedge core_clk) begin
        page_rx_valid <= send;
        page_rx_word <= send ? word : ~word;
    end
endmodule : gpnms_lp_model

// [gpnms_params.svh]
// gpnms_params.svh: offsets, field positions, reset values for the gigabit
// next page / control / status register slice.
// assumes: included by bare name; no clock or reset of its own.
`ifndef GPNMS_PARAMS_SVH
`define GPNMS_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define GPNMS_OFS_NEXT_PAGE 5'h08
`define GPNMS_OFS_CONTROL 5'h09
`define GPNMS_OFS_STATUS 5'h0a
// ----------------------------------------
// reset values
// ----------------------------------------
`define GPNMS_RST_NEXT_PAGE 16'h2001
`define GPNMS_RST_CONTROL 16'h0300
`define GPNMS_RST_STATUS 16'h0000
// ----------------------------------------
// field positions
// ----------------------------------------
`define GPNMS_NP_MORE 15
`define GPNMS_NP_ACK 14
`define GPNMS_NP_MSG 13
`define GPNMS_NP_ACK2 12
`define GPNMS_NP_TOGGLE 11
`define GPNMS_CTL_TEST_HI 15
`define GPNMS_CTL_TEST_LO 13
`define GPNMS_CTL_FORCE_EN 12
`define GPNMS_CTL_FORCE_VAL 11
`define GPNMS_CTL_PORT_TYPE 10
`define GPNMS_CTL_ADV_FD 9
`define GPNMS_CTL_ADV_HD 8
`define GPNMS_CTL_DIAG 7
`define GPNMS_CTL_WMASK 16'hff80
`define GPNMS_IDLE_MAX 8'hff
`define GPNMS_STRAP_SETTLE 2'h2
`endif

// [gpnms_pkg.sv]
// gpnms_pkg.sv: types shared by the register slice.
// assumes: compiled before the modules.
package gpnms_pkg;
    typedef enum logic [2:0] {
        GPNMS_TP_NORMAL,
        GPNMS_TP_WAVEFORM,
        GPNMS_TP_JITTER_MASTER,
        GPNMS_TP_JITTER_SLAVE,
        GPNMS_TP_DISTORTION,
        GPNMS_TP_MLT3_IDLES,
        GPNMS_TP_REPEAT_0001,
        GPNMS_TP_PULSE_63_ZEROS
    } gpnms_pattern_t;
    typedef logic [15:0] gpnms_word_t;
endpackage : gpnms_pkg

// [gpnms_regs.sv]
// gpnms_regs.sv: partner next page, gigabit control and gigabit status
// registers behind a simple management register port.
// assumes: event/status inputs are on core_clk; straps are pins and are
// synchronised; reads and writes are one-cycle strobes from the management
// serial engine.
`timescale 1ns/100ps
`include "gpnms_params.svh"
module gpnms_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // management register port
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output gpnms_pkg::gpnms_word_t reg_rdata,
    output logic reg_rvalid,
    // straps (pins)
    input wire logic strap_adv_full,
    input wire logic strap_adv_half,
    // negotiation engine
    input wire logic page_rx_valid,
    input wire logic [15:0] page_rx_word,
    input wire logic negotiation_restart,
    input wire logic partner_base_toggle,
    // master/slave and receiver status
    input wire logic role_fault_event,
    input wire logic role_resolved_master,
    input wire logic local_receiver_ok,
    input wire logic remote_receiver_ok,
    input wire logic partner_gig_full_duplex,
    input wire logic partner_gig_half_duplex,
    input wire logic idle_error_event,
    input wire logic link_down_event,
    // control outputs
    output gpnms_pkg::gpnms_pattern_t tx_pattern,
    output logic role_force_enable,
    output logic role_force_value,
    output logic port_multi,
    output logic adv_gig_full_duplex,
    output logic adv_gig_half_duplex,
    output logic cable_diag_start
);
    import gpnms_pkg::*;

    gpnms_word_t next_page_r;
    gpnms_word_t control_r;
    logic fault_r;
    logic [7:0] idle_count_r;
    logic [7:0] idle_count_nxt;
    logic [1:0] strap_sync;
    logic strap_done_r;
    logic [1:0] strap_wait_r;
    logic wr_control;
    logic first_page_r;
    gpnms_word_t rdata_nxt;
    logic rd_status;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == `GPNMS_IDLE_MAX) ? v : v + 8'h01;
    endfunction : sat_inc

    function automatic logic addr_is(input logic [4:0] a, input logic [4:0] ofs);
        addr_is = (a == ofs);
    endfunction : addr_is

    assign rd_status = reg_rd && addr_is(reg_addr, `GPNMS_OFS_STATUS);
    assign wr_control = reg_wr && addr_is(reg_addr, `GPNMS_OFS_CONTROL);

    // strap pins through two flops
    gpnms_sync2 #(.WIDTH(2)) u_strap_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in({strap_adv_full, strap_adv_half}),
        .sync_out(strap_sync)
    );

    // sync output is trusted only once both flops have refilled after reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_wait_r <= 2'h0;
        end else if (strap_wait_r != `GPNMS_STRAP_SETTLE) begin
            strap_wait_r <= strap_wait_r + 2'h1;
        end
    end

    // ----------------------------------------
    // partner next page capture
    // ----------------------------------------
    // first page of a negotiation alternates from base page bit
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            next_page_r <= `GPNMS_RST_NEXT_PAGE;
            first_page_r <= 1'b1;
        end else if (negotiation_restart) begin
            first_page_r <= 1'b1;
        end else if (page_rx_valid) begin
            first_page_r <= 1'b0;
            next_page_r[`GPNMS_NP_MORE] <= page_rx_word[`GPNMS_NP_MORE];
            next_page_r[`GPNMS_NP_ACK] <= page_rx_word[`GPNMS_NP_ACK];
            next_page_r[`GPNMS_NP_MSG] <= page_rx_word[`GPNMS_NP_MSG];
            next_page_r[`GPNMS_NP_ACK2] <= page_rx_word[`GPNMS_NP_ACK2];
            next_page_r[`GPNMS_NP_TOGGLE] <= first_page_r ? ~partner_base_toggle
                                                          : ~next_page_r[`GPNMS_NP_TOGGLE];
            next_page_r[10:0] <= page_rx_word[10:0];
        end
    end

    // ----------------------------------------
    // gigabit control register
    // ----------------------------------------
    // writes keep reserved low bits zero; settled straps load duplex defaults once
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            control_r <= `GPNMS_RST_CONTROL;
            strap_done_r <= 1'b0;
        end else if (wr_control) begin
            control_r <= reg_wdata & `GPNMS_CTL_WMASK;
            strap_done_r <= 1'b1;
        end else if (!strap_done_r && strap_wait_r == `GPNMS_STRAP_SETTLE) begin
            control_r[`GPNMS_CTL_ADV_FD] <= strap_sync[1];
            control_r[`GPNMS_CTL_ADV_HD] <= strap_sync[0];
            strap_done_r <= 1'b1;
        end
    end

    // control fields driven out from flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_pattern <= GPNMS_TP_NORMAL;
            role_force_enable <= 1'b0;
            role_force_value <= 1'b0;
            port_multi <= 1'b0;
            adv_gig_full_duplex <= 1'b1;
            adv_gig_half_duplex <= 1'b1;
        end else begin
            tx_pattern <= gpnms_pattern_t'(control_r[`GPNMS_CTL_TEST_HI:`GPNMS_CTL_TEST_LO]);
            role_force_enable <= control_r[`GPNMS_CTL_FORCE_EN];
            role_force_value <= control_r[`GPNMS_CTL_FORCE_VAL];
            port_multi <= control_r[`GPNMS_CTL_PORT_TYPE];
            adv_gig_full_duplex <= control_r[`GPNMS_CTL_ADV_FD];
            adv_gig_half_duplex <= control_r[`GPNMS_CTL_ADV_HD];
        end
    end

    // diagnostic launch pulse after link-down when enabled
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cable_diag_start <= 1'b0;
        end else begin
            cable_diag_start <= link_down_event && control_r[`GPNMS_CTL_DIAG];
        end
    end

    // ----------------------------------------
    // gigabit status latches
    // ----------------------------------------
    // fault latches high; a new fault beats the clear on read
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_r <= 1'b0;
        end else if (role_fault_event) begin
            fault_r <= 1'b1;
        end else if (rd_status) begin
            fault_r <= 1'b0;
        end
    end

    // idle error count saturates; read clears, event in same cycle counts one
    always_comb begin
        idle_count_nxt = idle_count_r;
        if (rd_status) begin
            idle_count_nxt = idle_error_event ? 8'h01 : 8'h00;
        end else if (idle_error_event) begin
            idle_count_nxt = sat_inc(idle_count_r);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_count_r <= 8'h00;
        end else begin
            idle_count_r <= idle_count_nxt;
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // unmapped offsets read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (addr_is(reg_addr, `GPNMS_OFS_NEXT_PAGE)) begin
            rdata_nxt = next_page_r;
        end else if (addr_is(reg_addr, `GPNMS_OFS_CONTROL)) begin
            rdata_nxt = control_r;
        end else if (addr_is(reg_addr, `GPNMS_OFS_STATUS)) begin
            rdata_nxt = {fault_r, role_resolved_master, local_receiver_ok,
                         remote_receiver_ok, partner_gig_full_duplex,
                         partner_gig_half_duplex, 2'b00, idle_count_r};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= `GPNMS_RST_STATUS;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_fault_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
        role_fault_event |=> fault_r) else $error("fault not latched");
    chk_fault_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        (rd_status && !role_fault_event) |=> !fault_r) else $error("fault not cleared by read");
    chk_idle_sat: assert property (@(posedge core_clk) disable iff (!reset_n)
        (idle_count_r == 8'hff && !rd_status) |=> idle_count_r == 8'hff) else $error("idle count wrapped");
    chk_idle_inc: assert property (@(posedge core_clk) disable iff (!reset_n)
        (idle_error_event && !rd_status && idle_count_r != 8'hff) |=> idle_count_r == $past(idle_count_r) + 8'h01)
        else $error("idle count did not step");
    chk_diag_launch: assert property (@(posedge core_clk) disable iff (!reset_n)
        cable_diag_start |-> $past(link_down_event) && $past(control_r[7])) else $error("diag without cause");
    chk_page_toggle: assert property (@(posedge core_clk) disable iff (!reset_n)
        (page_rx_valid && !negotiation_restart && !first_page_r) |=> next_page_r[11] != $past(next_page_r[11]))
        else $error("toggle did not alternate");
    chk_page_code: assert property (@(posedge core_clk) disable iff (!reset_n)
        (page_rx_valid && !negotiation_restart) |=> next_page_r[10:0] == $past(page_rx_word[10:0]))
        else $error("code field not captured");
    chk_ctl_reserved: assert property (@(posedge core_clk) disable iff (!reset_n)
        control_r[6:0] == 7'h00) else $error("reserved control bits set");
    chk_pattern_out: assert property (@(posedge core_clk) disable iff (!reset_n)
        ##1 tx_pattern == gpnms_pattern_t'($past(control_r[15:13]))) else $error("pattern mismatch");
    chk_force_out: assert property (@(posedge core_clk) disable iff (!reset_n)
        ##1 role_force_enable == $past(control_r[12])) else $error("force enable mismatch");
    // role value copied out one cycle late
    chk_role_value: assert property (@(posedge core_clk) disable iff (!reset_n)
        ##1 role_force_value == $past(control_r[11]))
        else $error("force value mismatch");
    // port type copied out one cycle late
    chk_port_out: assert property (@(posedge core_clk) disable iff (!reset_n)
        ##1 port_multi == $past(control_r[10]))
        else $error("port type mismatch");
    // duplex advertisements copied out one cycle late
    chk_adv_out: assert property (@(posedge core_clk) disable iff (!reset_n)
        ##1 {adv_gig_full_duplex, adv_gig_half_duplex} == $past(control_r[9:8]))
        else $error("advertise mismatch");
    // settled straps land in the duplex bits
    chk_strap_load: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!strap_done_r && strap_wait_r == `GPNMS_STRAP_SETTLE && !wr_control)
        |=> control_r[9:8] == $past(strap_sync))
        else $error("strap default not loaded");
    // control write keeps only writable fields
    chk_ctl_write: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_control |=> control_r == ($past(reg_wdata) & `GPNMS_CTL_WMASK))
        else $error("control write mismatch");
    // enabled link loss always launches the diagnostic
    chk_diag_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
        (link_down_event && control_r[7]) |=> cable_diag_start)
        else $error("diag not launched");

    // ----------------------------------------
    // checks: partner page capture
    // ----------------------------------------
    // page word only changes when a page arrives
    chk_page_ro: assert property (@(posedge core_clk) disable iff (!reset_n)
        !page_rx_valid |=> $stable(next_page_r))
        else $error("page register changed without a page");
    // flag bits taken from the received word
    chk_page_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
        (page_rx_valid && !negotiation_restart) |=> next_page_r[15:12] == $past(page_rx_word[15:12]))
        else $error("page flags not captured");
    // first page starts from the inverted base bit
    chk_page_first: assert property (@(posedge core_clk) disable iff (!reset_n)
        (page_rx_valid && !negotiation_restart && first_page_r)
        |=> next_page_r[11] == !$past(partner_base_toggle))
        else $error("first toggle wrong");
    // restart rearms the first-page state
    chk_page_rearm: assert property (@(posedge core_clk) disable iff (!reset_n)
        negotiation_restart |=> first_page_r)
        else $error("restart not taken");

    // ----------------------------------------
    // checks: status register and read port
    // ----------------------------------------
    // fault stays set until a status read
    chk_fault_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
        (fault_r && !rd_status) |=> fault_r)
        else $error("fault dropped without read");
    // status read returns the latched fault
    chk_fault_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        rd_status |=> reg_rdata[15] == $past(fault_r))
        else $error("fault not reported");
    // live levels shown as they stood at the read
    chk_status_live: assert property (@(posedge core_clk) disable iff (!reset_n)
        rd_status |=> reg_rdata[14] == $past(role_resolved_master)
        && reg_rdata[13] == $past(local_receiver_ok) && reg_rdata[12] == $past(remote_receiver_ok)
        && reg_rdata[11] == $past(partner_gig_full_duplex)
        && reg_rdata[10] == $past(partner_gig_half_duplex))
        else $error("status levels mismatch");
    // reserved status bits read zero
    chk_status_rsvd: assert property (@(posedge core_clk) disable iff (!reset_n)
        rd_status |=> reg_rdata[9:8] == 2'h0)
        else $error("reserved status bits set");
    // count shown as it stood at the read
    chk_idle_read: assert property (@(posedge core_clk) disable iff (!reset_n)
        rd_status |=> reg_rdata[7:0] == $past(idle_count_r))
        else $error("idle count not reported");
    // read clears the count; a same-cycle error counts one
    chk_idle_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
        rd_status |=> idle_count_r == {7'h00, $past(idle_error_event)})
        else $error("idle count not cleared");
    // count holds without an error or a read
    chk_idle_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!idle_error_event && !rd_status) |=> $stable(idle_count_r))
        else $error("idle count moved");
    // answer comes exactly one cycle after the strobe
    chk_read_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rd |=> reg_rvalid)
        else $error("read answer missing");
    // answer never appears without a strobe
    chk_answer_cause: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_rvalid |-> $past(reg_rd))
        else $error("read answer without strobe");
    // read data holds between reads
    chk_rdata_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");

    // ----------------------------------------
    // coverage of main scenarios
    // ----------------------------------------
    cov_page_rx: cover property (@(posedge core_clk) disable iff (!reset_n) page_rx_valid ##1 page_rx_valid);
    cov_fault_read: cover property (@(posedge core_clk) disable iff (!reset_n) role_fault_event ##[1:4] rd_status);
    cov_idle_full: cover property (@(posedge core_clk) disable iff (!reset_n) idle_count_r == 8'hff);
    cov_diag: cover property (@(posedge core_clk) disable iff (!reset_n) cable_diag_start);
    cov_fault_on_read: cover property (@(posedge core_clk) disable iff (!reset_n) role_fault_event && rd_status);
endmodule : gpnms_regs

// [gpnms_regs_tb.sv]
// gpnms_regs_tb.sv: self-checking bench for the gigabit register slice.
// assumes: one 10 MHz clock; inputs driven on the falling edge.
`timescale 1ns/100ps
`include "gpnms_params.svh"
module gpnms_regs_tb;
    import gpnms_pkg::*;
    logic core_clk, reset_n, reg_wr, reg_rd, reg_rvalid, strap_adv_full, strap_adv_half;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, page_rx_word, send_word, w;
    gpnms_word_t reg_rdata;
    gpnms_pattern_t tx_pattern;
    logic page_rx_valid, negotiation_restart, partner_base_toggle, role_fault_event;
    logic role_resolved_master, local_receiver_ok, remote_receiver_ok;
    logic partner_gig_full_duplex, partner_gig_half_duplex, idle_error_event, link_down_event;
    logic role_force_enable, role_force_value, port_multi, cable_diag_start, send, tg;
    logic adv_gig_full_duplex, adv_gig_half_duplex;
    int n_errors = 0;
    int total_checks = 0;
    int seed, i, n;
    gpnms_regs dut (.*);
    gpnms_lp_model lp (.core_clk, .send, .word(send_word), .page_rx_valid, .page_rx_word);
    // ----------------------------------------
    // clock and helpers
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task rdc(input logic [4:0] a, input logic [15:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk("rvalid", {15'h0, reg_rvalid}, 16'h0001);
        chk("rdata", reg_rdata, exp);
    endtask : rdc
    task wrt(input logic [4:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wrt
    function automatic logic [15:0] np_exp(input logic [15:0] d, input logic t);
        return {d[15:12], t, d[10:0]};
    endfunction : np_exp
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    // watchdog
    initial begin
        #500000;
        n_errors++;
        give_verdict();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hcdd3;
        {reg_wr, reg_rd, reg_addr, reg_wdata, send, send_word, negotiation_restart} = '0;
        {partner_base_toggle, role_fault_event, idle_error_event, link_down_event} = '0;
        {role_resolved_master, local_receiver_ok, remote_receiver_ok} = '0;
        {partner_gig_full_duplex, partner_gig_half_duplex} = '0;
        {strap_adv_full, strap_adv_half} = 2'b10;
        reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        rdc(5'h08, 16'h2001);
        rdc(5'h09, 16'h0200);
        chk("adv", {14'h0, adv_gig_full_duplex, adv_gig_half_duplex}, 16'h0002);
        rdc(5'h0a, 16'h0000);
        rdc(5'h1f, 16'h0000);
        wrt(5'h08, 16'h1234);
        rdc(5'h08, 16'h2001);
        // every pattern code with random other control bits
        for (i = 0; i < 8; i++) begin
            w = 16'($random(seed));
            w[15:13] = i[2:0];
            wrt(5'h09, w);
            @(negedge core_clk);
            chk("pattern", {13'h0, tx_pattern}, {13'h0, w[15:13]});
            chk("role", {14'h0, role_force_enable, role_force_value}, {14'h0, w[12:11]});
            chk("port", {13'h0, port_multi, adv_gig_full_duplex, adv_gig_half_duplex}, {13'h0, w[10:8]});
            rdc(5'h09, w & `GPNMS_CTL_WMASK);
        end
        // diagnostic launch after link loss, off then on
        for (i = 0; i < 2; i++) begin
            wrt(5'h09, {8'h03, i[0], 7'h00});
            @(negedge core_clk);
            link_down_event = 1'b1;
            @(negedge core_clk);
            link_down_event = 1'b0;
            chk("diag", {15'h0, cable_diag_start}, {15'h0, i[0]});
            @(negedge core_clk);
            chk("diag end", {15'h0, cable_diag_start}, 16'h0000);
        end
        // partner pages after two restarts; second base bit breaks plain alternation
        for (n = 0; n < 2; n++) begin
            partner_base_toggle = n ? tg : 1'($random(seed));
            tg = ~partner_base_toggle;
            negotiation_restart = 1'b1;
            @(negedge core_clk);
            negotiation_restart = 1'b0;
            for (i = 0; i < 4; i++) begin
                w = (i == 3) ? 16'hffff : 16'($random(seed));
                send_word = w;
                send = 1'b1;
                @(negedge core_clk);
                send = 1'b0;
                repeat (2) @(negedge core_clk);
                rdc(5'h08, np_exp(w, tg));
                tg = ~tg;
            end
        end
        // mid-run reset with other straps: page word back to reset, duplex reloaded
        {strap_adv_full, strap_adv_half} = 2'b01;
        reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        rdc(5'h08, 16'h2001);
        rdc(5'h09, 16'h0100);
        chk("adv", {14'h0, adv_gig_full_duplex, adv_gig_half_duplex}, 16'h0001);
        chk("pattern", {13'h0, tx_pattern}, 16'h0000);
        // fault latch and live status levels
        for (i = 0; i < 6; i++) begin
            w = 16'($random(seed));
            {role_resolved_master, local_receiver_ok, remote_receiver_ok} = w[14:12];
            {partner_gig_full_duplex, partner_gig_half_duplex} = w[11:10];
            role_fault_event = w[15];
            @(negedge core_clk);
            role_fault_event = 1'b0;
            repeat (2) @(negedge core_clk);
            rdc(5'h0a, {w[15:10], 10'h000});
            rdc(5'h0a, {1'b0, w[14:10], 10'h000});
        end
        {role_resolved_master, local_receiver_ok, remote_receiver_ok} = '0;
        {partner_gig_full_duplex, partner_gig_half_duplex} = '0;
        // idle errors: small count, then past saturation
        for (i = 0; i < 2; i++) begin
            n = i ? 300 : 5;
            repeat (n) begin
                idle_error_event = 1'b1;
                @(negedge core_clk);
                idle_error_event = 1'b0;
                @(negedge core_clk);
            end
            rdc(5'h0a, (n > 255) ? 16'h00ff : n[15:0]);
            rdc(5'h0a, 16'h0000);
        end
        // corner: fault and idle error in the very cycle of the clearing read
        @(negedge core_clk);
        reg_addr = 5'h0a;
        reg_rd = 1'b1;
        role_fault_event = 1'b1;
        idle_error_event = 1'b1;
        @(negedge core_clk);
        {reg_rd, role_fault_event, idle_error_event} = '0;
        chk("rdata", reg_rdata, 16'h0000);
        rdc(5'h0a, 16'h8001);
        rdc(5'h0a, 16'h0000);
        give_verdict();
    end
endmodule : gpnms_regs_tb

// [gpnms_sync2.sv]
// gpnms_sync2.sv: two-flop synchroniser for a bundle of levels.
// assumes: inputs come from outside core_clk's domain.
`timescale 1ns/100ps
module gpnms_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // first stage read only by second stage
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : gpnms_sync2
